/* File: hdl/sdh_consts.svh */
/* Register indices, error mask, timeout limits and timing constants of the bus control core.
   Assumes inclusion by bare name from the clock divider and bus control modules. */
`ifndef SDH_CONSTS_SVH
`define SDH_CONSTS_SVH
`define SDH_IX_PRES    8'h24
`define SDH_IX_HOST    8'h28
`define SDH_IX_PWR     8'h29
`define SDH_IX_GAP     8'h2a
`define SDH_IX_CLK     8'h2c
`define SDH_IX_TOUT    8'h2e
`define SDH_IX_SRST    8'h2f
`define SDH_IX_NSTS    8'h30
`define SDH_IX_ESTS    8'h32
`define SDH_ERR_MASK   16'h017f
`define SDH_TOUT_MAX   4'hd
`define SDH_TOUT_BASE  5'h0e
`define SDH_STABLE_NS  320
`define SDH_CLK_NS     40
`endif

/* File: hdl/sdh_pkg.sv */
/* Types shared by the bus control core.
   Assumes the constants header sits beside it. */
package sdh_pkg;
  typedef enum logic [2:0] {
    GAP_RUN  = 3'h1,
    GAP_WAIT = 3'h2,
    GAP_HALT = 3'h4
  } sdh_gap_t;
endpackage : sdh_pkg

/* File: hdl/sdh_clk_div.sv */
/* Card clock divider with stable flag and edge strobes.
   Assumes one system clock; divisor changed only while card clock is off. */
`timescale 1ns/1ns
`include "sdh_consts.svh"
module sdh_clk_div
  import sdh_pkg::*;
#(
  parameter int STABLE_CYCLES = (`SDH_STABLE_NS + `SDH_CLK_NS - 1) / `SDH_CLK_NS
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       int_en,
  input  wire logic       card_en,
  input  wire logic [9:0] divisor,
  // Status and clock
  output logic            stable_r,
  output logic            card_clk_r,
  output logic            rise_r,
  output logic            fall_r
);
  logic [9:0] cnt_r;
  logic [7:0] stab_cnt_r;
  logic       last;

  assign last = (divisor == 10'h000) || (cnt_r == divisor - 10'h001);

  always_ff @(posedge clk) begin
    if (sys_rst || !int_en) begin
      stab_cnt_r <= 8'h00;
      stable_r   <= 1'b0;
    end else if (stab_cnt_r == STABLE_CYCLES[7:0]) begin
      stable_r <= 1'b1;
    end else begin
      stab_cnt_r <= stab_cnt_r + 8'h01;
    end
  end

  // Zero divisor: one tick per base cycle, the pad bypass carries the clock
  always_ff @(posedge clk) begin
    if (sys_rst || !card_en || !stable_r) begin
      cnt_r      <= 10'h000;
      card_clk_r <= 1'b0;
      rise_r     <= 1'b0;
      fall_r     <= 1'b0;
    end else if (last) begin
      cnt_r      <= 10'h000;
      card_clk_r <= (divisor == 10'h000) ? 1'b0 : !card_clk_r;
      rise_r     <= (divisor == 10'h000) || !card_clk_r;
      fall_r     <= (divisor == 10'h000) || card_clk_r;
    end else begin
      cnt_r  <= cnt_r + 10'h001;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
  end
endmodule : sdh_clk_div

/* File: hdl/sdh_card_detect.sv */
/* Card detect synchroniser and debouncer.
   Assumes the detect pin is asynchronous and active low. */
`timescale 1ns/1ns
module sdh_card_detect
  import sdh_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 25000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin
  input  wire logic card_detect_pin_n,
  // Status
  output logic      level_r,
  output logic      inserted_r,
  output logic      stable_r,
  output logic      ins_evt_r,
  output logic      rem_evt_r
);
  logic        s1_r;
  logic        s2_r;
  logic [19:0] cnt_r;
  logic        settled_r;

  always_ff @(posedge clk) begin
    s1_r <= card_detect_pin_n;
    s2_r <= s1_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_r    <= 1'b0;
      cnt_r      <= 20'h00000;
      stable_r   <= 1'b0;
      inserted_r <= 1'b0;
      settled_r  <= 1'b0;
      ins_evt_r  <= 1'b0;
      rem_evt_r  <= 1'b0;
    end else begin
      level_r   <= !s2_r;
      ins_evt_r <= 1'b0;
      rem_evt_r <= 1'b0;
      if (level_r != !s2_r) begin
        cnt_r      <= 20'h00000;
        stable_r   <= 1'b0;
        inserted_r <= 1'b0;
      end else if (cnt_r != DEBOUNCE_CYCLES[19:0]) begin
        cnt_r <= cnt_r + 20'h00001;
      end else if (!stable_r) begin
        stable_r   <= 1'b1;
        inserted_r <= level_r;
        settled_r  <= level_r;
        ins_evt_r  <= level_r && !settled_r;
        rem_evt_r  <= !level_r && settled_r;
      end
    end
  end
endmodule : sdh_card_detect

/* File: hdl/sdh_bus_ctrl.sv */
/* Bus control and status core: Wishbone registers, bus width and edge,
   power, block gap, card clock, data timeout, line resets, events.
   Assumes datapath status inputs on clk; detect and card irq are pins. */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`include "sdh_consts.svh"
module sdh_bus_ctrl
  import sdh_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 25000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Datapath status
  input  wire logic        cmd_busy_i,
  input  wire logic        dat_busy_i,
  input  wire logic        dat_active_i,
  input  wire logic        wr_active_i,
  input  wire logic        rd_active_i,
  input  wire logic        buf_wr_ready_i,
  input  wire logic        buf_rd_ready_i,
  input  wire logic        at_block_gap_i,
  input  wire logic        dat_wait_i,
  input  wire logic [15:0] err_evt_i,
  // Card pins
  input  wire logic        card_detect_pin_n,
  input  wire logic        card_irq_pin_n,
  output logic             card_clk_r,
  output logic             card_clk_bypass_r,
  output logic             line_drive_en_r,
  // Datapath control
  output logic [1:0]       bus_width_r,
  output logic             launch_strobe_r,
  output logic             xfer_halt_r,
  output logic             continue_pulse_r,
  output logic             read_wait_en_r,
  output logic             gap_irq_en_r,
  output logic             cmd_reset_r,
  output logic             dat_reset_r
);
  // Registers
  logic [7:0]  host_r;
  logic        power_r;
  logic        gap_stop_r;
  logic        rdwait_r;
  logic        gapint_r;
  logic [15:0] clk_ctl_r;
  logic [3:0]  tout_r;
  logic [15:0] nsts_r;
  logic [15:0] ests_r;
  logic [31:0] pres_r;
  sdh_gap_t    gap_st_r;
  logic [27:0] tout_cnt_r;
  logic        irq_s1_r;
  logic        irq_s2_r;

  // Sub-block outputs
  logic       clk_stable;
  logic       div_clk;
  logic       div_rise;
  logic       div_fall;
  logic       cd_level;
  logic       cd_inserted;
  logic       cd_stable;
  logic       cd_ins;
  logic       cd_rem;

  // Bus decode
  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic [9:0] divisor;
  logic [27:0] tout_limit;
  logic       tout_hit;
  logic [15:0] card_evt_kept;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic [15:0] w1c(input logic [15:0] cur,
                                      input logic [15:0] d,
                                      input logic [1:0]  s);
    w1c = cur & ~{s[1] ? d[15:8] : 8'h00, s[0] ? d[7:0] : 8'h00};
  endfunction : w1c

  assign req     = cyc_i && stb_i && !ack_o;
  assign wr      = req && we_i;
  assign idx     = adr_i[9:2];
  assign divisor = {clk_ctl_r[7:6], clk_ctl_r[15:8]};

  // Limit 2^(14+v); reserved codes clamp to the largest legal one
  assign tout_limit = 28'h0000001 << ((tout_r > `SDH_TOUT_MAX) ?
                      (`SDH_TOUT_BASE + 5'(`SDH_TOUT_MAX)) :
                      (`SDH_TOUT_BASE + {1'b0, tout_r}));
  assign tout_hit   = (tout_cnt_r == tout_limit - 28'h0000001) && div_rise;

  // Insertion and removal bits after any write-one clear
  assign card_evt_kept = (wr && hit(idx, `SDH_IX_NSTS)) ?
                         w1c({8'h00, nsts_r[7:6], 6'h00}, dat_i[15:0], sel_i[1:0]) :
                         {8'h00, nsts_r[7:6], 6'h00};

  sdh_clk_div u_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .int_en   (clk_ctl_r[0]),
    .card_en  (clk_ctl_r[2] && power_r),
    .divisor  (divisor),
    .stable_r (clk_stable),
    .card_clk_r (div_clk),
    .rise_r   (div_rise),
    .fall_r   (div_fall)
  );

  sdh_card_detect #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_cd (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .card_detect_pin_n (card_detect_pin_n),
    .level_r           (cd_level),
    .inserted_r        (cd_inserted),
    .stable_r          (cd_stable),
    .ins_evt_r         (cd_ins),
    .rem_evt_r         (cd_rem)
  );

  // Acknowledge every access one cycle after the strobe, mapped or not
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dat_o <= 32'h00000000;
    end else if (req && !we_i) begin
      case (1'b1)
        hit(idx, `SDH_IX_PRES): dat_o <= pres_r;
        hit(idx, `SDH_IX_HOST): dat_o <= {24'h000000, host_r};
        hit(idx, `SDH_IX_PWR):  dat_o <= {31'h00000000, power_r};
        hit(idx, `SDH_IX_GAP):  dat_o <= {28'h0000000, gapint_r, rdwait_r,
                                         1'b0, gap_stop_r};
        hit(idx, `SDH_IX_CLK):  dat_o <= {16'h0000, clk_ctl_r[15:6], 3'h0,
                                         clk_ctl_r[2], clk_stable,
                                         clk_ctl_r[0]};
        hit(idx, `SDH_IX_TOUT): dat_o <= {28'h0000000, tout_r};
        hit(idx, `SDH_IX_NSTS): dat_o <= {16'h0000, nsts_r};
        hit(idx, `SDH_IX_ESTS): dat_o <= {16'h0000, ests_r};
        default:                dat_o <= 32'h00000000;
      endcase
    end
  end

  // Present state snapshot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pres_r <= 32'h00000000;
    end else begin
      pres_r <= {13'h0000, cd_level, cd_stable, cd_inserted,
                 4'h0, buf_rd_ready_i, buf_wr_ready_i,
                 rd_active_i, wr_active_i,
                 5'h00, dat_active_i,
                 dat_busy_i || gap_st_r == GAP_HALT,
                 cmd_busy_i};
    end
  end

  // Host control, power, timeout and clock control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_r    <= 8'h00;
      power_r   <= 1'b0;
      tout_r    <= 4'h0;
      clk_ctl_r <= 16'h0000;
    end else if (wr) begin
      if (hit(idx, `SDH_IX_HOST) && sel_i[0]) host_r <= dat_i[7:0] & 8'h26;
      if (hit(idx, `SDH_IX_PWR) && sel_i[0]) power_r <= dat_i[0];
      if (hit(idx, `SDH_IX_TOUT) && sel_i[0]) tout_r <= dat_i[3:0];
      if (hit(idx, `SDH_IX_CLK)) begin
        if (sel_i[0]) clk_ctl_r[7:0] <= dat_i[7:0] & 8'hc5;
        if (sel_i[1]) clk_ctl_r[15:8] <= dat_i[15:8];
      end
    end
  end

  // Bus width, edge, power gating of pins and clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_width_r       <= 2'h0;
      launch_strobe_r   <= 1'b0;
      line_drive_en_r   <= 1'b0;
      card_clk_r        <= 1'b0;
      card_clk_bypass_r <= 1'b0;
    end else begin
      bus_width_r     <= host_r[5] ? 2'h2 : {1'b0, host_r[1]};
      launch_strobe_r <= host_r[2] ? div_rise : div_fall;
      line_drive_en_r <= power_r;
      card_clk_r      <= power_r && div_clk;
      card_clk_bypass_r <= power_r && clk_ctl_r[2] && clk_stable &&
                           divisor == 10'h000;
    end
  end

  // Block gap control
  always_ff @(posedge clk) begin
    if (sys_rst || dat_reset_r) begin
      gap_stop_r       <= 1'b0;
      rdwait_r         <= 1'b0;
      gapint_r         <= 1'b0;
      continue_pulse_r <= 1'b0;
    end else begin
      continue_pulse_r <= 1'b0;
      if (wr && hit(idx, `SDH_IX_GAP) && sel_i[0]) begin
        gap_stop_r       <= dat_i[0];
        continue_pulse_r <= dat_i[1];
        rdwait_r         <= dat_i[2];
        gapint_r         <= dat_i[3];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || dat_reset_r) begin
      gap_st_r    <= GAP_RUN;
      xfer_halt_r <= 1'b0;
    end else begin
      case (gap_st_r)
        GAP_RUN: if (gap_stop_r) gap_st_r <= GAP_WAIT;
        GAP_WAIT: begin
          if (!gap_stop_r) begin
            gap_st_r <= GAP_RUN;
          end else if (at_block_gap_i) begin
            gap_st_r    <= GAP_HALT;
            xfer_halt_r <= 1'b1;
          end
        end
        GAP_HALT: begin
          if (continue_pulse_r) begin
            gap_st_r    <= GAP_RUN;
            xfer_halt_r <= 1'b0;
          end
        end
        default: gap_st_r <= GAP_RUN;
      endcase
    end
  end

  assign read_wait_en_r = rdwait_r;
  assign gap_irq_en_r   = gapint_r;

  // Line soft resets: one-cycle pulses, the bits read back as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reset_r <= 1'b0;
      dat_reset_r <= 1'b0;
    end else begin
      cmd_reset_r <= wr && hit(idx, `SDH_IX_SRST) && sel_i[0] && dat_i[1];
      dat_reset_r <= wr && hit(idx, `SDH_IX_SRST) && sel_i[0] && dat_i[2];
    end
  end

  // Data timeout counted in card clock periods
  always_ff @(posedge clk) begin
    if (sys_rst || dat_reset_r || !dat_wait_i || tout_hit) begin
      tout_cnt_r <= 28'h0000000;
    end else if (div_rise) begin
      tout_cnt_r <= tout_cnt_r + 28'h0000001;
    end
  end

  // Card interrupt pin is asynchronous
  always_ff @(posedge clk) begin
    irq_s1_r <= card_irq_pin_n;
    irq_s2_r <= irq_s1_r;
  end

  // Status: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ests_r <= 16'h0000;
    end else begin
      ests_r <= ((wr && hit(idx, `SDH_IX_ESTS)) ? w1c(ests_r, dat_i[15:0], sel_i[1:0])
                 : ests_r)
                | (err_evt_i & `SDH_ERR_MASK)
                | {11'h000, tout_hit, 4'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nsts_r <= 16'h0000;
    end else begin
      nsts_r[5:0]   <= 6'h00;
      nsts_r[14:9]  <= 6'h00;
      nsts_r[7:6]   <= card_evt_kept[7:6] | {cd_rem, cd_ins};
      nsts_r[8]     <= !irq_s2_r;
      nsts_r[15]    <= |ests_r;
    end
  end
endmodule : sdh_bus_ctrl

/* File: verif/sdh_card_model.sv */
/* Card-side model: slot switch and card interrupt line.
   Assumes the bench asks for insertion and interrupts; pins move on clk. */
`timescale 1ns/1ns
module sdh_card_model (
  // Clock and requests
  input  wire logic clk,
  input  wire logic insert,
  input  wire logic irq_req,
  // Card pins, active low
  output logic      card_detect_pin_n = 1'b1,
  output logic      card_irq_pin_n    = 1'b1
);
  // Switch grounds the pin while a card sits in the slot
  always @(posedge clk) card_detect_pin_n <= !insert;
  // Card holds its line low until its own cause is gone
  always @(posedge clk) card_irq_pin_n <= !irq_req;
endmodule : sdh_card_model

/* File: verif/sdh_bus_ctrl_asserts.sv */
/* Port checker for the bus control core.
   Assumes it is bound onto sdh_bus_ctrl; one clock domain. */
`timescale 1ns/1ns
module sdh_bus_ctrl_asserts (
  // Clock, reset, bus
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Card side and control
  input wire logic       at_block_gap_i,
  input wire logic       card_clk_r,
  input wire logic       card_clk_bypass_r,
  input wire logic       line_drive_en_r,
  input wire logic [1:0] bus_width_r,
  input wire logic       xfer_halt_r,
  input wire logic       continue_pulse_r,
  input wire logic       cmd_reset_r,
  input wire logic       dat_reset_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_follows_req:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_unpowered_quiet:
    assert property (!line_drive_en_r [*2] |-> !card_clk_r) else $error("clock while off");
  a_width_legal:
    assert property (bus_width_r != 2'h3) else $error("bad width code");
  a_bypass_still:
    assert property (card_clk_bypass_r |-> !card_clk_r) else $error("toggle in bypass");
  a_cont_one_cycle:
    assert property (continue_pulse_r |=> !continue_pulse_r) else $error("long continue");
  a_cont_ends_halt:
    assert property (continue_pulse_r && !at_block_gap_i |-> ##[1:2] !xfer_halt_r)
      else $error("halt stuck");
  a_halt_at_gap:
    assert property ($rose(xfer_halt_r) |-> $past(at_block_gap_i) || $past(at_block_gap_i, 2))
      else $error("halt off gap");
  a_cmd_rst_pulse:
    assert property (cmd_reset_r |=> !cmd_reset_r) else $error("long cmd reset");
  a_dat_rst_pulse:
    assert property (dat_reset_r |=> !dat_reset_r) else $error("long dat reset");
endmodule : sdh_bus_ctrl_asserts

bind sdh_bus_ctrl sdh_bus_ctrl_asserts sdh_bus_ctrl_asserts_inst (
  .clk, .sys_rst, .cyc_i, .stb_i, .ack_o, .at_block_gap_i, .card_clk_r,
  .card_clk_bypass_r, .line_drive_en_r, .bus_width_r, .xfer_halt_r,
  .continue_pulse_r, .cmd_reset_r, .dat_reset_r);

/* File: verif/sdh_bus_ctrl_tb.sv */
/* Register-level bench for the bus control core.
   Assumes a Wishbone slave that acks; card model drives the pins. */
`timescale 1ns/1ns
module sdh_bus_ctrl_tb;
  localparam int DB = 16;
  localparam logic [7:0] RIX [7] = '{8'h28, 8'h29, 8'h2a, 8'h2c, 8'h2e, 8'h2f, 8'h32};
  logic        clk = 1'b0, sys_rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [6:0]  dp = 7'h00;
  logic [15:0] err_evt_i = 16'h0000;
  logic        at_block_gap_i = 1'b0, dat_wait_i = 1'b0, ins = 1'b0, irq = 1'b0;
  logic        ack_o, card_clk_r, card_clk_bypass_r, line_drive_en_r, xfer_halt_r;
  logic        continue_pulse_r, read_wait_en_r, gap_irq_en_r, cmd_reset_r, dat_reset_r;
  logic [1:0]  bus_width_r;
  wire         card_detect_pin_n, card_irq_pin_n;
  logic [2:0]  seen = 3'h0;
  longint      t0 = 0, t1 = 0;
  int          mismatches = 0, n_checks = 0;

  initial forever #20 clk = ~clk;
  always @(posedge card_clk_r) begin
    t0 = t1;
    t1 = $time;
  end
  // Pulses are one cycle wide, so keep a sticky record
  // Cleared in reset so unknown outputs before the first edge do not stick
  always @(posedge clk) begin
    if (sys_rst) seen <= 3'h0;
    else seen <= seen | {dat_reset_r, cmd_reset_r, continue_pulse_r};
  end

  sdh_bus_ctrl #(.DEBOUNCE_CYCLES(DB)) sdh_bus_ctrl_inst (
    .clk, .sys_rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .cmd_busy_i(dp[0]), .dat_busy_i(dp[1]), .dat_active_i(dp[2]), .wr_active_i(dp[3]),
    .rd_active_i(dp[4]), .buf_wr_ready_i(dp[5]), .buf_rd_ready_i(dp[6]),
    .at_block_gap_i, .dat_wait_i, .err_evt_i, .card_detect_pin_n, .card_irq_pin_n,
    .card_clk_r, .card_clk_bypass_r, .line_drive_en_r, .bus_width_r, .launch_strobe_r(),
    .xfer_halt_r, .continue_pulse_r, .read_wait_en_r, .gap_irq_en_r, .cmd_reset_r,
    .dat_reset_r);
  sdh_card_model sdh_card_model_inst (
    .clk, .insert(ins), .irq_req(irq), .card_detect_pin_n, .card_irq_pin_n);

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(logic w, logic [7:0] ix, logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'h0};
    dat_i <= d;
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr(logic [7:0] ix, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ix, d, q);
  endtask : wr

  task automatic rc(string nm, logic [7:0] ix, logic [31:0] m, logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, ix, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rc

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    tick(3);
    sys_rst <= 1'b0;
    foreach (RIX[i]) rc("reset", RIX[i], 32'hffff, 32'h0);
    wr(8'h28, 32'h26);
    rc("host", 8'h28, 32'hff, 32'h26);
    tick(2);
    chk("width8", 32'h2, bus_width_r);
    wr(8'h28, 32'h02);
    tick(2);
    chk("width4", 32'h1, bus_width_r);
    wr(8'h28, 32'h0);
    tick(2);
    chk("width1", 32'h0, bus_width_r);
    wr(8'h29, 32'h1);
    tick(2);
    chk("drive", 32'h1, line_drive_en_r);
    wr(8'h2c, 32'h0101);
    rc("clk", 8'h2c, 32'hffff, 32'h0101);
    tick(10);
    rc("clk", 8'h2c, 32'hffff, 32'h0103);
    wr(8'h2c, 32'h0105);
    tick(20);
    chk("period", 32'd80, 32'(t1 - t0));
    wr(8'h2c, 32'h0141);
    wr(8'h2c, 32'h0145);
    tick(1100);
    chk("period", 32'd20560, 32'(t1 - t0));
    wr(8'h2c, 32'h0001);
    wr(8'h2c, 32'h0005);
    tick(3);
    chk("bypass", 32'h1, card_clk_bypass_r);
    wr(8'h2c, 32'h0101);
    wr(8'h2c, 32'h0105);
    wr(8'h2e, 32'h0);
    dat_wait_i <= 1'b1;
    tick(32000);
    rc("tout", 8'h32, 32'h10, 32'h0);
    tick(1000);
    rc("tout", 8'h32, 32'h10, 32'h10);
    dat_wait_i <= 1'b0;
    wr(8'h32, 32'h10);
    wr(8'h2e, 32'hff);
    rc("tsel", 8'h2e, 32'hff, 32'h0f);
    err_evt_i <= 16'h017f;
    tick(1);
    err_evt_i <= 16'h0000;
    tick(3);
    rc("err", 8'h32, 32'hffff, 32'h017f);
    wr(8'h32, 32'h7f);
    rc("err", 8'h32, 32'hffff, 32'h0100);
    rc("sum", 8'h30, 32'h8000, 32'h8000);
    wr(8'h32, 32'h100);
    rc("sum", 8'h30, 32'h8000, 32'h0);
    dp <= 7'h55;
    tick(2);
    rc("pres", 8'h24, 32'hf07, 32'h0a05);
    dp <= 7'h2a;
    tick(2);
    rc("pres", 8'h24, 32'hf07, 32'h0502);
    dp <= 7'h00;
    wr(8'h30, 32'hc0);
    ins <= 1'b1;
    tick(6);
    rc("bounce", 8'h24, 32'h70000, 32'h40000);
    tick(DB + 10);
    rc("ins", 8'h24, 32'h70000, 32'h70000);
    rc("insev", 8'h30, 32'hc0, 32'h40);
    wr(8'h30, 32'hc0);
    ins <= 1'b0;
    tick(DB + 10);
    rc("rem", 8'h24, 32'h70000, 32'h20000);
    rc("remev", 8'h30, 32'hc0, 32'h80);
    irq <= 1'b1;
    tick(5);
    wr(8'h30, 32'h100);
    rc("cirq", 8'h30, 32'h100, 32'h100);
    irq <= 1'b0;
    tick(5);
    rc("cirq", 8'h30, 32'h100, 32'h0);
    wr(8'h2a, 32'h0d);
    rc("gap", 8'h2a, 32'hff, 32'h0d);
    chk("rwait", 32'h1, read_wait_en_r);
    chk("gapirq", 32'h1, gap_irq_en_r);
    at_block_gap_i <= 1'b1;
    tick(4);
    chk("halt", 32'h1, xfer_halt_r);
    at_block_gap_i <= 1'b0;
    chk("idle", 32'h0, seen);
    wr(8'h2a, 32'h0f);
    tick(3);
    chk("cont", 32'h1, seen[0]);
    chk("halt", 32'h0, xfer_halt_r);
    rc("gap", 8'h2a, 32'hff, 32'h0d);
    wr(8'h2f, 32'h2);
    tick(2);
    chk("srst", 32'h1, seen[2:1]);
    wr(8'h2f, 32'h4);
    tick(2);
    chk("srst", 32'h3, seen[2:1]);
    wr(8'hff, 32'h5a);
    rc("unmap", 8'hff, 32'hffffffff, 32'h0);
    wr(8'h29, 32'h0);
    tick(3);
    chk("drive", 32'h0, line_drive_en_r);
    chk("cclk", 32'h0, card_clk_r);
    report_and_stop;
  end

  initial begin
    #(40 * 45000);
    mismatches++;
    report_and_stop;
  end
endmodule : sdh_bus_ctrl_tb
